// ---- src/ilss_pkg.sv ----
package ilss_pkg;

  // Instruction classes delivered by the predecoder with each instruction.
  localparam logic [4:0] CL_OTHER      = 5'h00; // No sequencing effect.
  localparam logic [4:0] CL_LOAD_A_IMM = 5'h01; // 4-bit immediate to A.
  localparam logic [4:0] CL_LOAD_EA_IMM= 5'h02; // 8-bit immediate to EA.
  localparam logic [4:0] CL_LOAD_HL_IMM= 5'h03; // 8-bit immediate to HL.
  localparam logic [4:0] CL_REF        = 5'h04; // One-byte table lookup.
  localparam logic [4:0] CL_TABLE_JUMP = 5'h05; // table_jump_pseudo.
  localparam logic [4:0] CL_TABLE_CALL = 5'h06; // table_subroutine_pseudo.
  localparam logic [4:0] CL_STEP_SKIP  = 5'h07; // Step and skip on wrap.
  localparam logic [4:0] CL_ADD_IMM_SKP= 5'h08; // add_immediate_skip.
  localparam logic [4:0] CL_BIT_TEST   = 5'h09; // Bit tests, skip on cond.
  localparam logic [4:0] CL_CMP_SKIP   = 5'h0a; // compare_skip_equal.
  localparam logic [4:0] CL_ADD_CARRY  = 5'h0b; // Add with carry.
  localparam logic [4:0] CL_SUB_BORROW = 5'h0c; // subtract_with_borrow_op.
  localparam logic [4:0] CL_CARRY_FLAG = 5'h0d; // Set, clear, invert carry.
  localparam logic [4:0] CL_INT_RETURN = 5'h0e; // interrupt_return_op.
  localparam logic [4:0] CL_BIT_CARRY  = 5'h0f; // Bit-to-carry and Booleans.
  localparam logic [4:0] CL_ROTATE     = 5'h10; // Rotate through carry.
  localparam logic [4:0] CL_LOAD_INDIR = 5'h11; // Pointer-indirect A load.
  localparam logic [4:0] CL_PTR_STEP   = 5'h12; // Pointer step with skip.
  localparam logic [4:0] CL_JUMP       = 5'h13; // Ordinary jump.
  localparam logic [4:0] CL_CALL       = 5'h14; // Ordinary call.

  // Lookup region bounds in program memory.
  localparam logic [11:0] REF_LO = 12'h020;
  localparam logic [11:0] REF_HI = 12'h07f;

  // Redundancy groups.
  localparam logic [1:0] RED_NONE = 2'h0;
  localparam logic [1:0] RED_ACC  = 2'h1;
  localparam logic [1:0] RED_PTR  = 2'h2;

  // Skip costs in extra machine cycles, and the long length code.
  localparam logic [1:0] SKIP_COST_NONE = 2'h0;
  localparam logic [1:0] SKIP_COST_SHORT= 2'h1;
  localparam logic [1:0] SKIP_COST_LONG = 2'h2;
  localparam logic [1:0] LEN_LONG       = 2'h3;

  // Bit addressing modes and their bases.
  localparam logic [1:0]  BM_MEMA = 2'h0;
  localparam logic [1:0]  BM_MEMB = 2'h1;
  localparam logic [1:0]  BM_HDA  = 2'h2;
  localparam logic [11:0] MEMA_LO = 12'hfb0;
  localparam logic [11:0] MEMA_HI = 12'hff0;
  localparam logic [11:0] MEMB_LO = 12'hfc0;
  localparam logic [3:0]  BANK_0  = 4'h0;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_REF1 = 3'b010,
    ST_REF2 = 3'b100
  } ilss_state_e;

  // True for classes allowed to write the carry flag.
  function automatic logic ilss_carry_cls(input logic [4:0] c);
    return (c == CL_ADD_CARRY) || (c == CL_SUB_BORROW) ||
           (c == CL_CARRY_FLAG) || (c == CL_INT_RETURN) ||
           (c == CL_BIT_CARRY) || (c == CL_ROTATE);
  endfunction

endpackage

// ---- src/ilss_bit_addr.sv ----
`timescale 1ns/10ps
`default_nettype none
// Forms the data-memory nibble address and bit index of a bit operand.
module ilss_bit_addr (
  // Operand fields.
  input  wire logic [1:0]  mode_i,
  input  wire logic [7:0]  direct_i,
  input  wire logic [1:0]  bit_sel_i,
  // Pointer and bank state.
  input  wire logic [3:0]  ptr_low_i,
  input  wire logic [3:0]  ptr_high_i,
  input  wire logic        memory_bank_enable_flag_i,
  input  wire logic [3:0]  bank_sel_i,
  // Result.
  output logic      [11:0] addr_o,
  output logic      [1:0]  idx_o,
  output logic             ok_o
);
  import ilss_pkg::*;

  // Pure decode; the caller registers the result.
  always_comb begin
    addr_o = MEMA_LO;
    idx_o  = bit_sel_i;
    ok_o   = 1'b1;
    case (mode_i)
      // Upper direct bit fields, flags window or port window.
      BM_MEMA: begin
        addr_o = (direct_i[4] ? MEMA_HI : MEMA_LO) | {8'h00, direct_i[3:0]};
      end
      // Low pointer nibble picks the word and the bit.
      BM_MEMB: begin
        addr_o = MEMB_LO | {6'h00, direct_i[3:0], ptr_low_i[3:2]};
        idx_o  = ptr_low_i[1:0];
      end
      // Bank from the enable flag and select value, then high nibble.
      BM_HDA: begin
        addr_o = {(memory_bank_enable_flag_i ? bank_sel_i : BANK_0),
                  ptr_high_i, direct_i[3:0]};
      end
      // Unused encoding is flagged so the datapath can ignore it.
      default: begin
        ok_o = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- src/ilss_seq.sv ----
`timescale 1ns/10ps
`default_nettype none
module ilss_seq #(
  parameter int PC_W = 12
) (
  // Clock and reset.
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  // Decoded instruction from program memory.
  input  wire logic                  instr_valid_i,
  input  wire logic [4:0]            instr_class_i,
  input  wire logic [7:0]            instr_opcode_i,
  input  wire logic [1:0]            instr_len_i,
  input  wire logic [PC_W-1:0]       instr_pc_i,
  // Datapath results for the same instruction.
  input  wire logic                  wrap_i,
  input  wire logic                  cond_i,
  input  wire logic                  branch_i,
  input  wire logic [PC_W-1:0]       branch_target_i,
  // Bit operand fields and bank state.
  input  wire logic [1:0]            bit_mode_i,
  input  wire logic [7:0]            bit_direct_i,
  input  wire logic [1:0]            bit_sel_i,
  input  wire logic [3:0]            ptr_low_i,
  input  wire logic [3:0]            ptr_high_i,
  input  wire logic                  memory_bank_enable_flag_i,
  input  wire logic [3:0]            bank_sel_i,
  // Sequencing results.
  output logic                       exec_o,
  output logic                       suppress_o,
  output logic                       carry_we_o,
  output logic [1:0]                 extra_cycles_o,
  output logic [PC_W-1:0]            fetch_addr_o,
  output logic                       push_ret_o,
  output logic [PC_W-1:0]            ret_addr_o,
  output logic                       in_table_o,
  output logic                       table_err_o,
  // Bit address.
  output logic [11:0]                bit_addr_o,
  output logic [1:0]                 bit_idx_o,
  output logic                       bit_ok_o
);
  import ilss_pkg::*;

  // The lookup region must fit in the program counter.
  if (PC_W < 8 || PC_W > 16) begin : g_chk
    $error("ilss_seq: PC_W must lie in 8..16");
  end

  // Whole state of the sequencer.
  typedef struct packed {
    ilss_state_e     st;        // Sequencing state.
    logic            skip_pend; // Next instruction is to be skipped.
    logic [1:0]      red;       // Active redundancy group.
    logic            adc_prev;  // Last executed was carry add/subtract.
    logic            adc_arm;   // And it asks to skip a following add-skip.
    logic [PC_W-1:0] ret_pc;    // Address after the lookup instruction.
    logic [PC_W-1:0] tbl_pc;    // Current lookup entry address.
    logic            exec, supp, carry_we, push, err, bit_ok, in_tbl;
    logic [1:0]      extra, bit_idx;
    logic [PC_W-1:0] fetch, ret_addr;
    logic [11:0]     bit_addr;
  } ilss_state_s;

  ilss_state_s      r_reg;      // Registered state.
  ilss_state_s      r_next;     // Next state.
  logic [PC_W-1:0]  seq_pc;     // Plain sequential successor.
  logic [PC_W-1:0]  ref_tgt;    // Lookup entry address, forced even.
  logic [1:0]       grp;        // Redundancy group of this instruction.
  logic             skipped;    // Instruction suppressed by a skip.
  logic [11:0]      ba_addr;
  logic [1:0]       ba_idx;
  logic             ba_ok;

  // Bit address decoder, registered below.
  ilss_bit_addr u_bit (
    .mode_i                    (bit_mode_i),
    .direct_i                  (bit_direct_i),
    .bit_sel_i                 (bit_sel_i),
    .ptr_low_i                 (ptr_low_i),
    .ptr_high_i                (ptr_high_i),
    .memory_bank_enable_flag_i (memory_bank_enable_flag_i),
    .bank_sel_i                (bank_sel_i),
    .addr_o                    (ba_addr),
    .idx_o                     (ba_idx),
    .ok_o                      (ba_ok)
  );

  // Helper terms shared by the next-state logic and the checks.
  always_comb begin
    seq_pc  = PC_W'(instr_pc_i + PC_W'(instr_len_i));
    // Entry start is even; the low opcode bit is ignored.
    ref_tgt = PC_W'({instr_opcode_i[6:1], 1'b0});
    case (instr_class_i)
      CL_LOAD_A_IMM, CL_LOAD_EA_IMM: grp = RED_ACC;
      CL_LOAD_HL_IMM:                grp = RED_PTR;
      default:                       grp = RED_NONE;
    endcase
    // An armed carry add/subtract skips the add-skip right after it.
    skipped = r_reg.skip_pend ||
              (r_reg.adc_arm && instr_class_i == CL_ADD_IMM_SKP);
  end

  // Next-state logic: one decision per delivered instruction.
  always_comb begin
    r_next          = r_reg;
    r_next.exec     = 1'b0;
    r_next.supp     = 1'b0;
    r_next.carry_we = 1'b0;
    r_next.extra    = SKIP_COST_NONE;
    r_next.push     = 1'b0;
    r_next.err      = 1'b0;
    r_next.bit_addr = ba_addr;
    r_next.bit_idx  = ba_idx;
    r_next.bit_ok   = ba_ok;
    if (instr_valid_i) begin
      r_next.skip_pend = 1'b0;
      r_next.adc_prev  = 1'b0;
      r_next.adc_arm   = 1'b0;
      // Default flow: leave the table, step through it, or step on sequentially when running.
      case (r_reg.st)
        ST_REF1: begin
          if (instr_len_i == 2'h1) begin
            r_next.st    = ST_REF2;
            r_next.fetch = PC_W'(r_reg.tbl_pc + 1'b1);
            // First of a pair must be an indirect load, MSB set.
            r_next.err = (instr_class_i != CL_LOAD_INDIR) ||
                         !instr_opcode_i[7];
          end else begin
            r_next.st    = ST_RUN;
            r_next.fetch = r_reg.ret_pc;
          end
        end
        ST_REF2: begin
          r_next.st    = ST_RUN;
          r_next.fetch = r_reg.ret_pc;
          // Second of a pair must be a pointer step-skip.
          r_next.err   = instr_class_i != CL_PTR_STEP;
        end
        default: begin
          r_next.st    = ST_RUN;
          r_next.fetch = seq_pc;
        end
      endcase
      if (skipped) begin
        // Fetched and stepped past, no effects; cost by length.
        r_next.supp = 1'b1;
        r_next.red  = RED_NONE;
        // A skipped lookup costs one cycle whatever it refers to.
        r_next.extra = (instr_len_i == LEN_LONG && instr_class_i != CL_REF) ?
                       SKIP_COST_LONG : SKIP_COST_SHORT;
      end else if (grp != RED_NONE && grp == r_reg.red) begin
        // Repeated immediate load acts as a no-op.
        r_next.supp = 1'b1;
      end else begin
        r_next.exec = 1'b1;
        r_next.red  = grp;
        case (instr_class_i)
          CL_REF: begin
            // Enter the table; the return point is saved.
            if (r_reg.st == ST_RUN) begin
              r_next.st     = ST_REF1;
              r_next.ret_pc = seq_pc;
              r_next.tbl_pc = ref_tgt;
              r_next.fetch  = ref_tgt;
              r_next.err    = ref_tgt < PC_W'(REF_LO) ||
                              ref_tgt > PC_W'(REF_HI);
            end
            r_next.red = RED_NONE; // Cancel earlier redundancy.
          end
          CL_STEP_SKIP, CL_PTR_STEP: r_next.skip_pend = wrap_i;
          // After carry add/subtract it cannot skip.
          CL_ADD_IMM_SKP: r_next.skip_pend = wrap_i && !r_reg.adc_prev;
          // Tests and compares skip on condition, carry untouched.
          CL_BIT_TEST, CL_CMP_SKIP: r_next.skip_pend = cond_i;
          CL_ADD_CARRY: begin
            r_next.carry_we = 1'b1;
            r_next.adc_prev = 1'b1;
            r_next.adc_arm  = wrap_i; // Overflow.
          end
          CL_SUB_BORROW: begin
            r_next.carry_we = 1'b1;
            r_next.adc_prev = 1'b1;
            r_next.adc_arm  = !wrap_i; // No borrow.
          end
          CL_CARRY_FLAG, CL_INT_RETURN, CL_BIT_CARRY,
          CL_ROTATE: r_next.carry_we = 1'b1;
          CL_TABLE_CALL, CL_CALL: begin
            // Return lands after the lookup when called from it.
            r_next.push     = 1'b1;
            r_next.ret_addr = (r_reg.st == ST_RUN) ? seq_pc : r_reg.ret_pc;
          end
          default: ;
        endcase
        // Any taken branch other than a lookup, table forms included, leaves the table.
        if (branch_i && instr_class_i != CL_REF) begin
          r_next.st    = ST_RUN;
          r_next.fetch = branch_target_i;
        end
      end
    end
    r_next.in_tbl = r_next.st != ST_RUN; // Registered copy of the state.
  end

  // State register; reset starts fetching at address zero.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg <= '{st: ST_RUN, red: RED_NONE, extra: SKIP_COST_NONE,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  assign exec_o         = r_reg.exec;
  assign suppress_o     = r_reg.supp;
  assign carry_we_o     = r_reg.carry_we;
  assign extra_cycles_o = r_reg.extra;
  assign fetch_addr_o   = r_reg.fetch;
  assign push_ret_o     = r_reg.push;
  assign ret_addr_o     = r_reg.ret_addr;
  assign in_table_o     = r_reg.in_tbl;
  assign table_err_o    = r_reg.err;
  assign bit_addr_o     = r_reg.bit_addr;
  assign bit_idx_o      = r_reg.bit_idx;
  assign bit_ok_o       = r_reg.bit_ok;

  AST_REF_ENTER: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && instr_class_i == CL_REF && r_reg.st == ST_RUN &&
    !skipped |=> fetch_addr_o == $past(ref_tgt) && in_table_o)
    else $error("lookup did not fetch its entry");
  AST_REF_RETURN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && r_reg.st == ST_REF1 && instr_len_i == 2'h2 &&
    !branch_i |=> fetch_addr_o == $past(r_reg.ret_pc) && !in_table_o)
    else $error("lookup did not resume after itself");
  AST_REF_SKIPPED: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && r_reg.skip_pend && instr_class_i == CL_REF
    |=> suppress_o && extra_cycles_o == 2'h1 && !in_table_o)
    else $error("skipped lookup mishandled");
  AST_ACC_REDUNDANT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && !skipped && r_reg.red == RED_ACC &&
    instr_class_i == CL_LOAD_EA_IMM |=> suppress_o && !exec_o)
    else $error("redundant accumulator load executed");
  AST_PTR_REDUNDANT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && !skipped && instr_class_i == CL_LOAD_HL_IMM
    ##1 instr_valid_i && !skipped && instr_class_i == CL_LOAD_HL_IMM
    |=> suppress_o && extra_cycles_o == 2'h0)
    else $error("redundant pointer load executed");
  AST_REF_CANCEL: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && !skipped && instr_class_i == CL_REF
    ##1 instr_valid_i && instr_class_i == CL_LOAD_EA_IMM &&
    !r_reg.skip_pend |=> exec_o)
    else $error("entry after lookup was suppressed");
  AST_STEP_SKIP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && !skipped && instr_class_i == CL_STEP_SKIP && wrap_i
    ##1 instr_valid_i |=> suppress_o && !carry_we_o)
    else $error("wrap did not skip the next instruction");
  AST_TEST_SKIP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && !skipped && instr_class_i == CL_BIT_TEST
    |=> !carry_we_o && r_reg.skip_pend == $past(cond_i))
    else $error("bit test skip wrong");
  AST_CARRY_ONLY: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    carry_we_o |-> $past(ilss_carry_cls(instr_class_i)) && exec_o)
    else $error("carry written by a foreign class");
  AST_ADC_ADS: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && r_reg.adc_arm && instr_class_i == CL_ADD_IMM_SKP
    |=> suppress_o && !exec_o && !r_reg.skip_pend)
    else $error("armed add-skip not bypassed");
  AST_SUPP_CLEAN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    instr_valid_i && r_reg.skip_pend && r_reg.st == ST_RUN
    |=> !exec_o && !carry_we_o && !push_ret_o &&
        fetch_addr_o == $past(seq_pc))
    else $error("suppressed instruction had an effect");
endmodule
`default_nettype wire

// ---- sim/ilss_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// Program memory model: the lookup region contents, predecoded.
// Reads are combinational so an entry is ready once fetch_addr_o lands.
module ilss_partner (
  // Fetch address from the sequencer.
  input  wire logic [11:0] addr_i,
  // Predecoded instruction.
  output logic      [4:0]  cls_o,
  output logic      [7:0]  op_o,
  output logic      [1:0]  len_o
);
  import ilss_pkg::*;
  logic [14:0] ent; // Class, opcode and length packed together.

  // Entries start at even addresses; anything else reads as a plain op.
  always_comb begin
    case (addr_i)
      12'h020: ent = {CL_LOAD_EA_IMM, 8'h8e, 2'h2};
      12'h022: ent = {CL_LOAD_INDIR, 8'h8b, 2'h1};
      12'h023: ent = {CL_PTR_STEP, 8'h4c, 2'h1};
      12'h024: ent = {CL_TABLE_JUMP, 8'h90, 2'h2};
      12'h026: ent = {CL_TABLE_CALL, 8'h94, 2'h2};
      // Bad pair: first opcode has its top bit clear, used on purpose.
      12'h028: ent = {CL_LOAD_INDIR, 8'h0b, 2'h1};
      12'h029: ent = {CL_PTR_STEP, 8'h4c, 2'h1};
      default: ent = {CL_OTHER, 8'h00, 2'h1};
    endcase
  end
  assign cls_o = ent[14:10];
  assign op_o  = ent[9:2];
  assign len_o = ent[1:0];
endmodule
`default_nettype wire

// ---- sim/instr_lookup_skip_sequencer_test.sv ----
`timescale 1ns/10ps
`default_nettype none
// Directed bench for the lookup, redundancy and skip sequencer.
module instr_lookup_skip_sequencer_test;
  import ilss_pkg::*;
  // Drives of the instruction and bit ports.
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        vld = 1'b0;
  logic [4:0]  cls = CL_OTHER;
  logic [7:0]  opc = 8'h00;
  logic [1:0]  len = 2'h1;
  logic [11:0] pc = 12'h000;
  logic        wrap = 1'b0;
  logic        cnd = 1'b0;
  logic        br = 1'b0;
  logic [1:0]  bm = 2'h0;
  logic [7:0]  bd = 8'h00;
  logic [3:0]  pl = 4'h0;
  logic [3:0]  ph = 4'h0;
  logic        mbe = 1'b0;
  // Observed outputs of the design and of program memory.
  logic        ex, sp, cw, pr, it, te, bo;
  logic [1:0]  xc, bi, p_len;
  logic [11:0] fa, ra, ba;
  logic [4:0]  p_cls;
  logic [7:0]  p_op;
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;

  // 200 MHz clock.
  always #2.5 clk = ~clk;

  ilss_seq #(.PC_W(12)) dut (
    .core_clk_i(clk), .reset_n_i(rst_n), .instr_valid_i(vld),
    .instr_class_i(cls), .instr_opcode_i(opc), .instr_len_i(len),
    .instr_pc_i(pc), .wrap_i(wrap), .cond_i(cnd), .branch_i(br),
    .branch_target_i(12'h345), .bit_mode_i(bm), .bit_direct_i(bd),
    .bit_sel_i(2'h3), .ptr_low_i(pl), .ptr_high_i(ph),
    .memory_bank_enable_flag_i(mbe), .bank_sel_i(4'h2),
    .exec_o(ex), .suppress_o(sp), .carry_we_o(cw), .extra_cycles_o(xc),
    .fetch_addr_o(fa), .push_ret_o(pr), .ret_addr_o(ra), .in_table_o(it),
    .table_err_o(te), .bit_addr_o(ba), .bit_idx_o(bi), .bit_ok_o(bo)
  );
  ilss_partner mem (.addr_i(fa), .cls_o(p_cls), .op_o(p_op), .len_o(p_len));

  // A hang is cut short well after the expected run of about 80 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // Offers one instruction at a falling edge; valid stays up so that
  // consecutive offers are back to back. Returns just after the rising edge.
  task automatic offer(input logic [4:0] c, input logic [7:0] o,
                       input logic [1:0] l, input logic [11:0] a,
                       input logic w, input logic k, input logic b);
    @(negedge clk);
    vld = 1'b1;
    cls = c;
    opc = o;
    len = l;
    pc = a;
    wrap = w;
    cnd = k;
    br = b;
    @(posedge clk);
    #1;
  endtask

  // Offers what program memory holds at the current fetch address.
  task automatic ent(input logic w, input logic b);
    offer(p_cls, p_op, p_len, fa, w, 1'b0, b);
  endtask

  task automatic idle;
    @(negedge clk);
    vld = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Compares the per-instruction verdict outputs.
  task automatic exp(input logic e, input logic s, input logic c, input logic [1:0] x);
    chk("exec_o", 12'(ex), 12'(e));
    chk("suppress_o", 12'(sp), 12'(s));
    chk("carry_we_o", 12'(cw), 12'(c));
    chk("extra_cycles_o", 12'(xc), 12'(x));
  endtask

  // Reset in mid-run; fetch address and table flag must clear while it is held.
  task automatic rst;
    @(negedge clk);
    rst_n = 1'b0;
    vld = 1'b0;
    @(negedge clk);
    chk("fetch_reset", fa, 12'h000);
    chk("table_reset", 12'(it), 12'h000);
    rst_n = 1'b1;
  endtask

  task automatic t_lookup;
    offer(CL_REF, 8'h20, 2'h1, 12'h100, 1'b0, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    chk("fetch_addr_o", fa, 12'h020);
    chk("in_table_o", 12'(it), 12'h001);
    ent(1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    chk("fetch_addr_o", fa, 12'h101);
    chk("in_table_o", 12'(it), 12'h000);
    offer(CL_REF, 8'h02, 2'h1, 12'h101, 1'b0, 1'b0, 1'b0);
    chk("table_err_o", 12'(te), 12'h001);
    rst();
    $display("test lookup done");
  endtask

  task automatic t_branch;
    offer(CL_REF, 8'h24, 2'h1, 12'h200, 1'b0, 1'b0, 1'b0);
    ent(1'b0, 1'b1);
    chk("fetch_addr_o", fa, 12'h345);
    chk("in_table_o", 12'(it), 12'h000);
    offer(CL_REF, 8'h26, 2'h1, 12'h345, 1'b0, 1'b0, 1'b0);
    ent(1'b0, 1'b1);
    chk("push_ret_o", 12'(pr), 12'h001);
    chk("ret_addr_o", ra, 12'h346);
    chk("fetch_addr_o", fa, 12'h345);
    idle();
    $display("test branch done");
  endtask

  task automatic t_skip;
    offer(CL_STEP_SKIP, 8'h00, 2'h1, 12'h300, 1'b1, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    offer(CL_REF, 8'h20, 2'h1, 12'h301, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h1);
    chk("fetch_addr_o", fa, 12'h302);
    offer(CL_ADD_IMM_SKP, 8'h00, 2'h1, 12'h302, 1'b1, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    offer(CL_OTHER, 8'h00, 2'h3, 12'h303, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h2);
    chk("fetch_addr_o", fa, 12'h306);
    offer(CL_STEP_SKIP, 8'h00, 2'h1, 12'h306, 1'b0, 1'b0, 1'b0);
    offer(CL_OTHER, 8'h00, 2'h2, 12'h307, 1'b0, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    idle();
    $display("test skip done");
  endtask

  task automatic t_pair;
    offer(CL_REF, 8'h22, 2'h1, 12'h400, 1'b0, 1'b0, 1'b0);
    ent(1'b0, 1'b0);
    ent(1'b1, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    chk("fetch_addr_o", fa, 12'h401);
    chk("table_err_o", 12'(te), 12'h000);
    offer(CL_OTHER, 8'h00, 2'h1, 12'h401, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h1);
    offer(CL_REF, 8'h28, 2'h1, 12'h402, 1'b0, 1'b0, 1'b0);
    ent(1'b0, 1'b0);
    chk("table_err_o", 12'(te), 12'h001);
    ent(1'b0, 1'b0);
    chk("fetch_addr_o", fa, 12'h403);
    idle();
    $display("test pair done");
  endtask

  task automatic t_redund;
    offer(CL_LOAD_A_IMM, 8'h00, 2'h1, 12'h500, 1'b0, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    offer(CL_LOAD_EA_IMM, 8'h00, 2'h2, 12'h501, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h0);
    chk("fetch_addr_o", fa, 12'h503);
    offer(CL_LOAD_A_IMM, 8'h00, 2'h1, 12'h503, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h0);
    offer(CL_LOAD_HL_IMM, 8'h00, 2'h2, 12'h504, 1'b0, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    offer(CL_LOAD_HL_IMM, 8'h00, 2'h2, 12'h506, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h0);
    offer(CL_LOAD_A_IMM, 8'h00, 2'h1, 12'h508, 1'b0, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    idle();
    $display("test redundancy done");
  endtask

  task automatic t_refred;
    offer(CL_LOAD_EA_IMM, 8'h00, 2'h2, 12'h600, 1'b0, 1'b0, 1'b0);
    offer(CL_REF, 8'h20, 2'h1, 12'h602, 1'b0, 1'b0, 1'b0);
    ent(1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    offer(CL_LOAD_EA_IMM, 8'h00, 2'h2, 12'h603, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h0);
    idle();
    $display("test lookup redundancy done");
  endtask

  task automatic t_carry;
    // Every carry-writing class, with an overflow that must not skip.
    for (int i = 11; i <= 16; i++) begin
      offer(5'(i), 8'h00, 2'h1, 12'h700 + 12'(i), 1'b1, 1'b0, 1'b0);
      exp(1'b1, 1'b0, 1'b1, 2'h0);
    end
    offer(CL_OTHER, 8'h00, 2'h1, 12'h720, 1'b1, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    offer(CL_BIT_TEST, 8'h00, 2'h2, 12'h721, 1'b0, 1'b1, 1'b0);
    offer(CL_OTHER, 8'h00, 2'h1, 12'h723, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h1);
    offer(CL_CMP_SKIP, 8'h00, 2'h1, 12'h724, 1'b0, 1'b1, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    offer(CL_OTHER, 8'h00, 2'h2, 12'h725, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h1);
    idle();
    $display("test carry done");
  endtask

  task automatic t_adc;
    offer(CL_ADD_CARRY, 8'h00, 2'h1, 12'h800, 1'b1, 1'b0, 1'b0);
    offer(CL_ADD_IMM_SKP, 8'h00, 2'h1, 12'h801, 1'b1, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h1);
    offer(CL_OTHER, 8'h00, 2'h1, 12'h802, 1'b0, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    offer(CL_SUB_BORROW, 8'h00, 2'h1, 12'h803, 1'b0, 1'b0, 1'b0);
    offer(CL_ADD_IMM_SKP, 8'h00, 2'h1, 12'h804, 1'b0, 1'b0, 1'b0);
    exp(1'b0, 1'b1, 1'b0, 2'h1);
    offer(CL_SUB_BORROW, 8'h00, 2'h1, 12'h805, 1'b1, 1'b0, 1'b0);
    offer(CL_ADD_IMM_SKP, 8'h00, 2'h1, 12'h806, 1'b1, 1'b0, 1'b0);
    offer(CL_OTHER, 8'h00, 2'h1, 12'h807, 1'b0, 1'b0, 1'b0);
    exp(1'b1, 1'b0, 1'b0, 2'h0);
    idle();
    $display("test carry skip done");
  endtask

  // Drives one bit operand and compares the formed address one edge later.
  task automatic bitx(input logic [1:0] m, input logic [7:0] d,
                      input logic [3:0] l, input logic [3:0] h, input logic e,
                      input logic [11:0] ea, input logic [1:0] ei);
    @(negedge clk);
    bm = m;
    bd = d;
    pl = l;
    ph = h;
    mbe = e;
    @(posedge clk);
    #1;
    chk("bit_addr_o", ba, ea);
    chk("bit_idx_o", 12'(bi), 12'(ei));
    // Mode 3 is the unused encoding and must be flagged.
    chk("bit_ok_o", 12'(bo), 12'(m != 2'h3));
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_lookup();
    t_branch();
    t_skip();
    t_pair();
    t_redund();
    t_refred();
    t_carry();
    t_adc();
    bitx(2'h0, 8'h05, 4'h0, 4'h0, 1'b0, 12'hfb5, 2'h3);
    bitx(2'h0, 8'h1a, 4'h0, 4'h0, 1'b0, 12'hffa, 2'h3);
    bitx(2'h1, 8'h03, 4'he, 4'h0, 1'b0, 12'hfcf, 2'h2);
    bitx(2'h2, 8'h09, 4'h0, 4'h7, 1'b1, 12'h279, 2'h3);
    bitx(2'h2, 8'h09, 4'h0, 4'h7, 1'b0, 12'h079, 2'h3);
    bitx(2'h3, 8'h09, 4'h0, 4'h7, 1'b0, 12'hfb0, 2'h3);
    $display("test bit address done");
    finish_test();
  end
endmodule
`default_nettype wire
